/* pp_pkg.sv */
// Package of constants and types for the printer port with EPP cycles
package pp_pkg;

  localparam int PP_AW = 8;

  localparam logic [7:0] PP_OFF_DATA     = 8'h00;
  localparam logic [7:0] PP_OFF_STAT     = 8'h04;
  localparam logic [7:0] PP_OFF_CTRL     = 8'h08;
  localparam logic [7:0] PP_OFF_EPP_ADDR = 8'h0C;
  localparam logic [7:0] PP_OFF_EPP_DATA = 8'h10;
  localparam logic [7:0] PP_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] PP_OFF_IRQ_MASK = 8'h18;

  localparam int PP_CLK_NS     = 25;
  localparam int PP_EPP_TO_NS  = 10000;
  localparam int PP_EPP_TO_CYC = PP_EPP_TO_NS / PP_CLK_NS;
  localparam int PP_CNT_W      = 16;

  localparam int PP_NEV        = 3;
  localparam int PP_EV_RECEIPT = 0;
  localparam int PP_EV_FAULT   = 1;
  localparam int PP_EV_TIMEOUT = 2;

  typedef struct packed {
    logic epp_en;
    logic dir;
    logic selin;
    logic init;
    logic autofd;
    logic strobe;
  } pp_ctrl_s;

  localparam pp_ctrl_s PP_CTRL_RST = 6'h00;

  typedef struct packed {
    logic       busy;
    logic       no_media;
    logic       online;
    logic       fault_n;
    logic       receipt_n;
    logic [1:0] rsv;
    logic       timeout;
  } pp_stat_s;

  typedef enum logic [3:0] {
    PP_IDLE   = 4'h1,
    PP_SETUP  = 4'h2,
    PP_STROBE = 4'h4,
    PP_DONE   = 4'h8
  } pp_epp_e;

  typedef struct packed {
    logic addr_n;
    logic data_n;
    logic write_n;
  } pp_strb_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pp_pin_s;

  typedef struct packed {
    pp_epp_e              st;
    pp_ctrl_s             ctrl;
    logic [7:0]           data;
    logic [7:0]           rd;
    logic                 is_addr;
    logic                 is_write;
    logic [PP_CNT_W-1:0]  cnt;
    logic                 timeout;
    logic                 receipt_d;
    logic                 fault_d;
  } pp_main_s;

  typedef struct packed {
    logic [PP_NEV-1:0] stat;
    logic [PP_NEV-1:0] mask;
  } pp_irq_s;

endpackage

/* pp_pin_mux.sv */
// Pin function selection between printer and EPP modes
`timescale 1ns/1ps
`default_nettype none
module pp_pin_mux
  import pp_pkg::*;
(
  // Controls
  input  wire pp_ctrl_s ctrl,
  input  wire pp_strb_s strb,
  // Pins
  output pp_pin_s       lf_pin,
  output pp_pin_s       sel_pin,
  output pp_pin_s       stb_pin,
  output pp_pin_s       init_pin
);

  always_comb begin
    // Reset pin is open drain in both modes
    init_pin = '{out: 1'b0, oe: !ctrl.init};
    if (ctrl.epp_en) begin
      // Push-pull strobes in EPP mode
      lf_pin  = '{out: strb.data_n,  oe: 1'b1};
      sel_pin = '{out: strb.addr_n,  oe: 1'b1};
      stb_pin = '{out: strb.write_n, oe: 1'b1};
    end else begin
      lf_pin  = '{out: 1'b0, oe: ctrl.autofd};
      sel_pin = '{out: 1'b0, oe: ctrl.selin};
      stb_pin = '{out: 1'b0, oe: ctrl.strobe};
    end
  end

  chk_epp_pins : assert final (
    !ctrl.epp_en || (lf_pin.oe && sel_pin.oe && stb_pin.oe))
    else $error("strobe pin floating in EPP mode");
  chk_lf_float : assert final (
    ctrl.epp_en || ctrl.autofd || !lf_pin.oe)
    else $error("line feed driven while its bit is zero");
  chk_init_drive : assert final (
    ctrl.init || (init_pin.oe && !init_pin.out))
    else $error("printer reset not driven low");
  chk_init_rel : assert final (
    !ctrl.init || !init_pin.oe)
    else $error("printer reset driven while its bit is one");

endmodule
`default_nettype wire

/* pp_irq.sv */
// Sticky event status with mask and read clear
`timescale 1ns/1ps
`default_nettype none
module pp_irq
  import pp_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Events and software access
  input  wire logic [PP_NEV-1:0] ev,
  input  wire logic              stat_rd,
  input  wire logic              mask_wr,
  input  wire logic [PP_NEV-1:0] mask_wdata,
  // State
  output logic      [PP_NEV-1:0] stat,
  output logic      [PP_NEV-1:0] mask,
  output logic                   irq
);

  pp_irq_s s_reg;
  pp_irq_s s_next;

  always_comb begin
    s_next = s_reg;
    // Set wins over read clear
    s_next.stat = (stat_rd ? '0 : s_reg.stat) | ev;
    if (mask_wr) begin
      s_next.mask = mask_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stat = s_reg.stat;
  assign mask = s_reg.mask;
  assign irq  = |(s_reg.stat & s_reg.mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_irq_sticky : assert property (
    ((ev & mask) != '0) |=> irq[*2] or (irq ##1 $past(stat_rd)))
    else $error("unmasked event did not hold interrupt");

endmodule
`default_nettype wire

/* pp_port.sv */
// Printer port top: APB registers, EPP cycle engine and pin control
`timescale 1ns/1ps
`default_nettype none
module pp_port
  import pp_pkg::*;
#(
  parameter int EPP_TO_CYC = PP_EPP_TO_CYC
) (
  // APB slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [PP_AW-1:0] paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Interrupt
  output logic                  irq,
  // Printer status inputs
  input  wire logic             receipt_n_in,
  input  wire logic             busy_wait_in,
  input  wire logic             fault_n_in,
  input  wire logic             no_media_in,
  input  wire logic             printer_online_in,
  // Data bus
  input  wire logic [7:0]       port_data_bus_in,
  output logic      [7:0]       port_data_bus_out,
  output logic                  port_data_bus_oe,
  // Control and strobe outputs
  output logic                  line_feed_auto_out,
  output logic                  line_feed_auto_oe,
  output logic                  device_choose_out,
  output logic                  device_choose_oe,
  output logic                  char_strobe_out,
  output logic                  char_strobe_oe,
  output logic                  printer_init_out,
  output logic                  printer_init_oe
);

  if (EPP_TO_CYC < 1 || EPP_TO_CYC >= (1 << PP_CNT_W)) begin : g_chk
    $error("EPP_TO_CYC out of range");
  end

  localparam logic [PP_CNT_W-1:0] TO_LIM = PP_CNT_W'(EPP_TO_CYC);

  function automatic logic is_epp(input logic [PP_AW-1:0] a);
    return (a == PP_OFF_EPP_ADDR) || (a == PP_OFF_EPP_DATA);
  endfunction

  function automatic logic is_mapped(input logic [PP_AW-1:0] a);
    return is_epp(a) || (a == PP_OFF_DATA) || (a == PP_OFF_STAT) ||
           (a == PP_OFF_CTRL) || (a == PP_OFF_IRQ_STAT) ||
           (a == PP_OFF_IRQ_MASK);
  endfunction

  pp_main_s          s_reg;
  pp_main_s          s_next;
  pp_strb_s          strb;
  pp_pin_s           lf_pin;
  pp_pin_s           sel_pin;
  pp_pin_s           stb_pin;
  pp_pin_s           init_pin;
  pp_stat_s          stat;
  logic [PP_NEV-1:0] ev;
  logic [PP_NEV-1:0] irq_stat;
  logic [PP_NEV-1:0] irq_mask;
  logic              epp_sel;
  logic              start;
  logic              done;
  logic              wr_en;
  logic              rd_en;
  logic              abort;

  // Bus decode
  assign epp_sel = s_reg.ctrl.epp_en && is_epp(paddr);
  assign start   = psel && !penable && epp_sel && (s_reg.st == PP_IDLE);
  assign done    = s_reg.st == PP_DONE;
  assign pready  = !(psel && penable && epp_sel) || done;
  assign pslverr = psel && penable && pready &&
                   (!is_mapped(paddr) || (epp_sel && s_reg.timeout));
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_en   = psel && penable && pready && !pwrite;
  // Wait held low past the limit ends the cycle
  assign abort   = (s_reg.st == PP_STROBE) && !busy_wait_in &&
                   (s_reg.cnt == TO_LIM);

  always_comb begin
    s_next           = s_reg;
    s_next.receipt_d = receipt_n_in;
    s_next.fault_d   = fault_n_in;
    if (wr_en && paddr == PP_OFF_CTRL) begin
      s_next.ctrl = pwdata[5:0];
    end
    if (wr_en && paddr == PP_OFF_DATA) begin
      s_next.data = pwdata[7:0];
    end
    unique case (s_reg.st)
      PP_IDLE: begin
        if (start) begin
          s_next.st       = PP_SETUP;
          s_next.is_addr  = paddr == PP_OFF_EPP_ADDR;
          s_next.is_write = pwrite;
          s_next.timeout  = 1'b0;
          s_next.cnt      = '0;
          if (pwrite) begin
            s_next.data = pwdata[7:0];
          end
        end
      end
      PP_SETUP: begin
        s_next.st = PP_STROBE;
      end
      PP_STROBE: begin
        if (busy_wait_in) begin
          // Peripheral ready: close the cycle
          s_next.st = PP_DONE;
          if (!s_reg.is_write) begin
            s_next.rd = port_data_bus_in;
          end
        end else if (abort) begin
          s_next.st      = PP_DONE;
          s_next.timeout = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
      end
      PP_DONE: begin
        s_next.st = PP_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg           <= '0;
      s_reg.st        <= PP_IDLE;
      s_reg.ctrl      <= PP_CTRL_RST;
      s_reg.receipt_d <= 1'b1;
      s_reg.fault_d   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // EPP strobes: address and data low only in the strobe phase, write low from setup through strobe
  always_comb begin
    strb.addr_n  = !((s_reg.st == PP_STROBE) && s_reg.is_addr);
    strb.data_n  = !((s_reg.st == PP_STROBE) && !s_reg.is_addr);
    strb.write_n = !(s_reg.is_write &&
                    (s_reg.st == PP_SETUP || s_reg.st == PP_STROBE));
  end

  pp_pin_mux u_mux (
    .ctrl     (s_reg.ctrl),
    .strb     (strb),
    .lf_pin   (lf_pin),
    .sel_pin  (sel_pin),
    .stb_pin  (stb_pin),
    .init_pin (init_pin)
  );

  assign line_feed_auto_out = lf_pin.out;
  assign line_feed_auto_oe  = lf_pin.oe;
  assign device_choose_out  = sel_pin.out;
  assign device_choose_oe   = sel_pin.oe;
  assign char_strobe_out    = stb_pin.out;
  assign char_strobe_oe     = stb_pin.oe;
  assign printer_init_out   = init_pin.out;
  assign printer_init_oe    = init_pin.oe;

  // Data bus direction by mode
  assign port_data_bus_out = s_reg.data;
  assign port_data_bus_oe  = s_reg.ctrl.epp_en ?
                             (s_reg.is_write && s_reg.st != PP_IDLE) :
                             !s_reg.ctrl.dir;

  // Status inputs as seen by software
  always_comb begin
    stat           = '0;
    stat.busy      = busy_wait_in;
    stat.no_media  = no_media_in;
    stat.online    = printer_online_in;
    stat.fault_n   = fault_n_in;
    stat.receipt_n = receipt_n_in;
    stat.timeout   = s_reg.timeout;
  end

  // Falling edges of receipt and fault, and aborts
  always_comb begin
    ev                = '0;
    ev[PP_EV_RECEIPT] = s_reg.receipt_d && !receipt_n_in;
    ev[PP_EV_FAULT]   = s_reg.fault_d && !fault_n_in;
    ev[PP_EV_TIMEOUT] = abort;
  end

  pp_irq u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .ev         (ev),
    .stat_rd    (rd_en && paddr == PP_OFF_IRQ_STAT),
    .mask_wr    (wr_en && paddr == PP_OFF_IRQ_MASK),
    .mask_wdata (pwdata[PP_NEV-1:0]),
    .stat       (irq_stat),
    .mask       (irq_mask),
    .irq        (irq)
  );

  always_comb begin
    prdata = '0;
    if (psel) begin
      unique case (paddr)
        PP_OFF_DATA:     prdata[7:0] = s_reg.ctrl.dir ?
                                       port_data_bus_in : s_reg.data;
        PP_OFF_STAT:     prdata[7:0] = stat;
        PP_OFF_CTRL:     prdata[5:0] = s_reg.ctrl;
        PP_OFF_EPP_ADDR,
        PP_OFF_EPP_DATA: prdata[7:0] = s_reg.ctrl.epp_en ? s_reg.rd : 8'h00;
        PP_OFF_IRQ_STAT: prdata[PP_NEV-1:0] = irq_stat;
        PP_OFF_IRQ_MASK: prdata[PP_NEV-1:0] = irq_mask;
        default:         prdata = '0;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write_setup;
    s_reg.st == PP_SETUP && s_reg.is_write;
  endsequence

  sequence s_strobe_wait;
    s_reg.st == PP_STROBE && !busy_wait_in && !abort;
  endsequence

  sequence s_cycle_open;
    start;
  endsequence

  sequence s_cycle_front;
    s_reg.st == PP_SETUP ##1 s_reg.st == PP_STROBE;
  endsequence

  chk_abort_release : assert property (
    abort |=> strb.addr_n && strb.data_n && strb.write_n &&
              s_reg.timeout && pready)
    else $error("aborted cycle left a strobe low");

  chk_wait_extend : assert property (
    s_strobe_wait |=> s_reg.st == PP_STROBE && !pready)
    else $error("cycle ended while wait held low");

  chk_data_strobe : assert property (
    (s_reg.st == PP_STROBE && !s_reg.is_addr && s_reg.ctrl.epp_en)
      |-> !line_feed_auto_out && line_feed_auto_oe)
    else $error("data strobe not low in data cycle");

  chk_addr_strobe : assert property (
    (s_reg.st == PP_STROBE && s_reg.is_addr && s_reg.ctrl.epp_en)
      |-> !device_choose_out && device_choose_oe && line_feed_auto_out)
    else $error("address strobe not low in address cycle");

  chk_write_strobe : assert property (
    (s_write_setup and s_reg.ctrl.epp_en) |-> !char_strobe_out
      ##1 (!char_strobe_out && port_data_bus_oe))
    else $error("write strobe not low through write cycle");

  chk_read_capture : assert property (
    (s_reg.st == PP_STROBE && busy_wait_in && !s_reg.is_write)
      |=> s_reg.rd == $past(port_data_bus_in) && done)
    else $error("read byte not captured");

  chk_mode_select : assert property (
    !s_reg.ctrl.epp_en |-> char_strobe_oe == s_reg.ctrl.strobe &&
      device_choose_oe == s_reg.ctrl.selin && !char_strobe_out)
    else $error("printer mode pins not under control bits");

  chk_strobe_float : assert property (
    (!s_reg.ctrl.epp_en && !s_reg.ctrl.strobe) |-> !char_strobe_oe)
    else $error("character strobe driven with bit zero");

  chk_choose_float : assert property (
    (!s_reg.ctrl.epp_en && !s_reg.ctrl.selin) |-> !device_choose_oe)
    else $error("select output driven with bit zero");

  chk_autofd_drive : assert property (
    (!s_reg.ctrl.epp_en && s_reg.ctrl.autofd)
      |-> line_feed_auto_oe && !line_feed_auto_out)
    else $error("line feed not driven low");

  chk_timeout_len : assert property (
    $rose(s_reg.st == PP_STROBE) && !busy_wait_in ##1 !busy_wait_in
      |-> s_reg.cnt == PP_CNT_W'(1))
    else $error("wait counter not advancing");

  chk_cycle_front : assert property (
    s_cycle_open |=> s_cycle_front)
    else $error("EPP cycle did not reach its strobe phase");

  chk_setup_quiet : assert property (
    s_reg.st == PP_SETUP |-> strb.addr_n && strb.data_n)
    else $error("address or data strobe low in setup phase");

  chk_idle_strobes : assert property (
    s_reg.st == PP_IDLE |-> strb.addr_n && strb.data_n && strb.write_n)
    else $error("strobe low with no EPP cycle");

  chk_read_quiet : assert property (
    (s_reg.ctrl.epp_en && !s_reg.is_write && s_reg.st != PP_IDLE)
      |-> strb.write_n && !port_data_bus_oe)
    else $error("write strobe or bus drive in read cycle");

  chk_abort_error : assert property (
    abort |=> !(psel && penable && epp_sel) || pslverr)
    else $error("aborted cycle ended without error");

  chk_abort_event : assert property (
    abort |=> irq_stat[PP_EV_TIMEOUT])
    else $error("aborted cycle raised no timeout event");

  chk_wait_bound : assert property (
    s_reg.cnt <= TO_LIM)
    else $error("wait counter ran past its limit");

  chk_init_pin : assert property (
    printer_init_oe == !s_reg.ctrl.init && !printer_init_out)
    else $error("printer reset pin not under its bit");

  chk_lf_release : assert property (
    (!s_reg.ctrl.epp_en && !s_reg.ctrl.autofd) |-> !line_feed_auto_oe)
    else $error("line feed driven with bit zero");

  chk_bus_printer : assert property (
    !s_reg.ctrl.epp_en |-> port_data_bus_oe == !s_reg.ctrl.dir &&
      port_data_bus_out == s_reg.data)
    else $error("printer mode data bus not under its register");

  chk_unmapped_err : assert property (
    (psel && penable && !is_mapped(paddr)) |-> pready && pslverr)
    else $error("unmapped access not refused");

  chk_refused_read : assert property (
    (psel && !s_reg.ctrl.epp_en && is_epp(paddr)) |-> prdata == '0)
    else $error("EPP register read outside EPP mode");

endmodule
`default_nettype wire

/* pp_peer.sv */
// Far-side model: EPP peripheral and printer on the port pins
`timescale 1ns/1ps
`default_nettype none
module pp_peer (
  // Clock and behaviour
  input  wire logic       pclk,
  input  wire logic       epp,
  input  wire logic       drv_en,
  input  wire logic [9:0] wait_cyc,
  input  wire logic       busy,
  input  wire logic [7:0] rd_byte,
  // Port pins
  input  wire logic       lf_out,
  input  wire logic       dc_out,
  input  wire logic       cs_out,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  output logic            wait_busy,
  output logic      [7:0] bus_in
);
  logic [9:0] cnt = 10'h000;
  logic [7:0] last = 8'h00;
  logic       act;
  logic       drv;
  assign act = epp && (!lf_out || !dc_out);
  assign drv = drv_en || (act && cs_out);
  always @(posedge pclk) begin
    cnt <= act ? cnt + 10'h001 : 10'h000;
    last <= bus_in;
  end
  // Wait low for wait_cyc strobe cycles; plain busy level in printer mode
  assign wait_busy = epp ? !(act && cnt < wait_cyc) : busy;
  // Nobody driving: the bus shows the complement of its value one cycle earlier
  always_comb begin
    if (bus_oe) begin
      bus_in = bus_out;
    end else if (drv) begin
      bus_in = rd_byte;
    end else begin
      bus_in = ~last;
    end
  end
endmodule
`default_nettype wire

/* test_pp_port.sv */
// Self-checking bench for the printer port pins and EPP cycles
`timescale 1ns/1ps
`default_nettype none
module test_pp_port
  import pp_pkg::*;
;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [PP_AW-1:0] paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             irq;
  logic             receipt_n = 1'b1;
  logic             fault_n = 1'b1;
  logic             no_media = 1'b0;
  logic             online = 1'b1;
  logic             busy = 1'b0;
  logic             epp = 1'b0;
  logic             drv_en = 1'b0;
  logic [9:0]       wait_cyc = 10'h000;
  logic [7:0]       rd_byte = 8'h00;
  logic             wait_busy;
  logic [7:0]       bus_in;
  logic [7:0]       bus_out;
  logic             bus_oe;
  logic             lf_out, lf_oe, dc_out, dc_oe;
  logic             cs_out, cs_oe, in_out, in_oe;
  logic [7:0]       pins;
  logic [31:0]      r;
  logic             e;
  logic [2:0]       lo;
  logic [7:0]       acc;
  int               err_count = 0;
  int               tests_run = 0;

  assign pins = {lf_oe, dc_oe, cs_oe, in_oe, lf_out, dc_out, cs_out, in_out};

  always #12.5 pclk = ~pclk;

  pp_port #(.EPP_TO_CYC(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .receipt_n_in(receipt_n), .busy_wait_in(wait_busy),
    .fault_n_in(fault_n), .no_media_in(no_media),
    .printer_online_in(online), .port_data_bus_in(bus_in),
    .port_data_bus_out(bus_out), .port_data_bus_oe(bus_oe),
    .line_feed_auto_out(lf_out), .line_feed_auto_oe(lf_oe),
    .device_choose_out(dc_out), .device_choose_oe(dc_oe),
    .char_strobe_out(cs_out), .char_strobe_oe(cs_oe),
    .printer_init_out(in_out), .printer_init_oe(in_oe));

  pp_peer peer (
    .pclk(pclk), .epp(epp), .drv_en(drv_en), .wait_cyc(wait_cyc),
    .busy(busy), .rd_byte(rd_byte), .lf_out(lf_out), .dc_out(dc_out),
    .cs_out(cs_out), .bus_out(bus_out), .bus_oe(bus_oe),
    .wait_busy(wait_busy), .bus_in(bus_in));

  task automatic stop_test();
    $display("Counts: %0d mismatches, %0d comparisons", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; notes which strobes went low during access
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    lo = 3'b000;
    n = 0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      lo = lo | ~{lf_out, dc_out, cs_out};
    end while (pready !== 1'b1 && n < 1000);
    r = prdata;
    e = pslverr;
    acc = 8'(n);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 1000) begin
      err_count++;
      stop_test();
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    chk({24'h0, pins}, 32'h00000010);
    repeat (15) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, PP_OFF_CTRL, 32'h0000000B);
    repeat (2) @(posedge pclk);
    chk({24'h0, pins}, 32'h000000F0);
    apb(1'b1, PP_OFF_CTRL, 32'h00000004);
    repeat (2) @(posedge pclk);
    chk({24'h0, pins}, 32'h00000000);
    apb(1'b1, PP_OFF_DATA, 32'h000000A5);
    repeat (2) @(posedge pclk);
    chk({23'h0, bus_oe, bus_out}, 32'h000001A5);
    rd_byte <= 8'h3C;
    drv_en <= 1'b1;
    apb(1'b1, PP_OFF_CTRL, 32'h00000010);
    apb(1'b0, PP_OFF_DATA, 32'h0);
    chk(r, 32'h0000003C);
    drv_en <= 1'b0;
    busy <= 1'b1;
    no_media <= 1'b1;
    online <= 1'b0;
    fault_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, PP_OFF_STAT, 32'h0);
    chk(r, 32'h000000C8);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, PP_OFF_IRQ_STAT, 32'h0);
    chk(r, 32'h00000002);
    apb(1'b1, PP_OFF_IRQ_MASK, 32'h00000001);
    receipt_n <= 1'b0;
    repeat (2) @(posedge pclk);
    receipt_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, PP_OFF_IRQ_STAT, 32'h0);
    chk(r, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    busy <= 1'b0;
    apb(1'b1, PP_OFF_CTRL, 32'h00000020);
    epp <= 1'b1;
    wait_cyc <= 10'd2;
    apb(1'b1, PP_OFF_EPP_DATA, 32'h0000005A);
    chk({28'h0, e, lo}, 32'h00000005);
    chk({24'h0, acc}, 32'h00000005);
    wait_cyc <= 10'd0;
    apb(1'b1, PP_OFF_EPP_ADDR, 32'h00000033);
    chk({28'h0, e, lo}, 32'h00000003);
    rd_byte <= 8'h96;
    apb(1'b0, PP_OFF_EPP_ADDR, 32'h0);
    chk({19'h0, acc, e, lo, r[7:0] == 8'h96}, 32'h00000065);
    wait_cyc <= 10'd1000;
    apb(1'b0, PP_OFF_EPP_DATA, 32'h0);
    chk({28'h0, e, lo}, 32'h0000000C);
    repeat (2) @(posedge pclk);
    chk({29'h0, lf_out, dc_out, cs_out}, 32'h00000007);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, PP_OFF_STAT, 32'h0);
    chk({31'h0, r[0]}, 32'h1);
    apb(1'b0, PP_OFF_IRQ_STAT, 32'h0);
    chk(r, 32'h00000004);
    apb(1'b1, PP_OFF_CTRL, 32'h00000000);
    apb(1'b0, PP_OFF_EPP_ADDR, 32'h0);
    chk({r[22:0], acc, e}, 32'h00000002);
    apb(1'b0, 8'h1C, 32'h0);
    chk({r[30:0], e}, 32'h00000001);
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
